/* File: tsg_bit_src.sv */
// External bitstream source: one bit of a repeating 4-bit pattern per 16 clocks.
// Restarts its cadence on an align rise so the core samples mid-bit.
`timescale 1ns/10ps
module tsg_bit_src (
    // Clock and reset
    input wire logic  clk_sys,
    input wire logic  rst_n,
    // Control
    input wire logic  align_pin,
    input wire logic [3:0] pattern,
    // Pin
    output logic      bit_out
);
    logic [3:0] cnt_r;
    logic [1:0] idx_r;
    logic       align_d_r;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 4'h0;
            idx_r <= 2'h0;
            align_d_r <= 1'b0;
            bit_out <= 1'b0;
        end
        else
        begin
            align_d_r <= align_pin;
            cnt_r <= (align_pin && !align_d_r) ? 4'h1 : cnt_r + 4'h1;
            if (align_pin && !align_d_r)
            begin
                bit_out <= pattern[0];
                idx_r <= 2'h1;
            end
            else if (cnt_r == 4'h0)
            begin
                bit_out <= pattern[idx_r];
                idx_r <= idx_r + 2'h1;
            end
        end
    end
endmodule

/* File: tsg_consts.svh */
// Register offsets, field positions, reset values and timing counts of the
// test signal generator. Included by tsg_core.sv only.
`ifndef TSG_CONSTS_SVH
`define TSG_CONSTS_SVH

// Register word offsets on the plain register port
`define TSG_OFS_GAIN_MODE 3'h0
`define TSG_OFS_RATE      3'h1
`define TSG_OFS_ATTEN     3'h2
`define TSG_OFS_LEVEL     3'h3
`define TSG_OFS_PULSE     3'h4
`define TSG_OFS_STATUS    3'h5

// Field positions
`define TSG_GAIN_LSB      0
`define TSG_MODE_LSB      3
`define TSG_DIV_LSB       0
`define TSG_MUL_LSB       8
`define TSG_HALVE_BIT     12
`define TSG_PA_LSB        0
`define TSG_PB_LSB        5
`define TSG_ST_PHASE_LSB  0
`define TSG_ST_MODE_LSB   10
`define TSG_ST_ALIGN_BIT  12

// Reset values
`define TSG_RST_GAIN      3'h0
`define TSG_RST_MUL       4'h0
`define TSG_RST_DIV       8'h00
`define TSG_RST_ATTEN     8'h00
`define TSG_RST_LEVEL     24'h000000
`define TSG_RST_PULSE     5'h00

// Analog gain: highest defined code, held for the reserved code
`define TSG_GAIN_MAX      3'h6

// Bitstream timing in master clock cycles
`define TSG_BIT_PERIOD    16
`define TSG_ALIGN_DELAY   8

`endif

/* File: tsg_core.sv */
// Digital core of a seismic test signal generator: sine, dc level, pulse
// and external bitstream paths, with a plain register port.
// Assumes one clock clk_sys as master clock; align and bitstream pins are
// asynchronous and are synchronised here.
//
// Function
// (RULE1) Sine frequency is 250 Hz at 4.096 MHz over two to the halve bit, times multiplier+1 over divisor+1; the code caps it at 250 Hz.
// (RULE2) Writing multiplier or divisor restarts the sine at its zero crossing.
// (RULE3) A rising align pin in sine mode restarts the sine at its zero crossing.
// (RULE4) The three-bit analog gain attenuates in 6 dB steps from 0 dB at 000 to -36 dB at 110.
// (RULE5) The digital level attenuates 0.5 dB per count to -119.5 dB, and upper nibble 1111 mutes.
// (RULE6) Sine amplitude in dB is the analog gain plus the digital attenuation.
// (RULE7) The host should prefer low analog gain and high digital gain for best noise.
// (RULE8) DC mode outputs the 24-bit two's-complement level within the selected analog range.
// (RULE9) Pulse mode drives the first step level with align low and the second with align high.
// (RULE10) Pulse levels ignore the analog gain setting.
// (RULE11) Pulse codes are sign-magnitude, roughly logarithmic, and passed to the pulse converter.
// (RULE12) Data mode bypasses the generator and takes the pin bitstream at one sixteenth of clock.
// (RULE13) Output follows ones-density, zero at 50 percent, full scale at 25 and 75 percent.
// (RULE14) In data mode the analog gain scales the filtered bitstream range.
// (RULE15) The mode field selects sine 00, dc 01, external data 10, pulse 11.
// (RULE16) In data mode a rising align zeroes output and samples on the eighth edge, then every 16.
// (RULE17) Reserved analog gain code 111 holds the -36 dB setting.
`timescale 1ns/10ps
`include "tsg_consts.svh"

module tsg_core #(
    parameter int ADDR_W = 3
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    // Pins
    input  wire logic              align_pin,
    input  wire logic              switch_or_bitstream_pin,
    // Converter drive
    output tsg_pkg::tsg_drive_t    drive
);

    // Refuse widths the decode cannot serve and a bit period the divider cannot hold
    if (ADDR_W < 3 || ADDR_W > 16)
    begin
        $error("ADDR_W must be 3 to 16");
    end
    if (`TSG_BIT_PERIOD > 16 || `TSG_ALIGN_DELAY >= `TSG_BIT_PERIOD)
    begin
        $error("bit period must fit the 4-bit divider");
    end

    // 10^(-r/40) in Q16, r = 0..11: one 0.5 dB step per count
    // Only the remainder of a division by 12 reaches it; other codes give unity
    function automatic logic [16:0] tsg_step_gain(input logic [3:0] r);
        logic [16:0] g;
        g = 17'h10000;
        case (r)
            4'h1: g = 17'd61870;
            4'h2: g = 17'd58409;
            4'h3: g = 17'd55142;
            4'h4: g = 17'd52057;
            4'h5: g = 17'd49145;
            4'h6: g = 17'd46396;
            4'h7: g = 17'd43801;
            4'h8: g = 17'd41350;
            4'h9: g = 17'd39037;
            4'ha: g = 17'd36854;
            4'hb: g = 17'd34792;
            default: g = 17'h10000;
        endcase
        return g;
    endfunction

    // Word decode of one register offset; upper address bits
    // must be zero for a hit, so aliases never answer
    function automatic logic tsg_hit(input logic [ADDR_W-1:0] a, input logic [2:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // Registers
    // Fields keep their value across mode changes
    logic [2:0]  gain_r;
    tsg_pkg::tsg_mode_t mode_r;
    logic [3:0]  mul_r;
    logic [7:0]  div_r;
    logic        halve_r;
    logic [7:0]  atten_r;
    logic [23:0] level_r;
    logic [4:0]  pa_r;
    logic [4:0]  pb_r;

    // Pin synchronisers
    logic [1:0]  align_sync_r;
    logic [1:0]  bits_sync_r;
    logic        align_d_r;

    // Generator state
    // Sample path, modulator and converter drive
    logic [3:0]  tick_cnt_r;
    logic [9:0]  frac_r;
    logic [9:0]  phase_r;
    logic [23:0] sine_r;
    logic [23:0] att_r;
    logic [23:0] acc_r;
    logic        bit_r;
    logic        strobe_r;
    logic        zero_r;
    logic        psel_r;
    logic [4:0]  pcode_r;
    logic [2:0]  range_r;
    logic [31:0] rdata_r;

    // Register decode
    // Status is read-only; a write to it or to a free word has no effect
    wire addr_hit_gm   = tsg_hit(reg_addr, `TSG_OFS_GAIN_MODE);
    wire addr_hit_rate = tsg_hit(reg_addr, `TSG_OFS_RATE);
    wire addr_hit_att  = tsg_hit(reg_addr, `TSG_OFS_ATTEN);
    wire addr_hit_lvl  = tsg_hit(reg_addr, `TSG_OFS_LEVEL);
    wire addr_hit_pul  = tsg_hit(reg_addr, `TSG_OFS_PULSE);
    wire addr_hit_st   = tsg_hit(reg_addr, `TSG_OFS_STATUS);
    wire wr_rate       = reg_wr && addr_hit_rate;

    wire align_s   = align_sync_r[1];
    wire align_up  = align_s && !align_d_r;
    wire is_sine   = mode_r == tsg_pkg::TSG_MODE_SINE;
    wire is_data   = mode_r == tsg_pkg::TSG_MODE_DATA;
    wire is_pulse  = mode_r == tsg_pkg::TSG_MODE_PULSE;
    wire tick      = tick_cnt_r == 4'h0;

    // Sine restart
    // Any rate write restarts, whatever the mode, so a later sine starts clean
    wire restart   = wr_rate || (is_sine && align_up);          // RULE2 RULE3

    // Rational phase stepping, 1024 steps per period
    wire [9:0]  frac_inc  = {6'h00, mul_r} + 10'h001;           // RULE1
    wire [9:0]  frac_lim  = ({2'b00, div_r} + 10'h001) << halve_r; // RULE1
    wire [10:0] frac_sum  = {1'b0, frac_r} + {1'b0, frac_inc};
    wire        frac_wrap = frac_sum >= {1'b0, frac_lim};
    wire [9:0]  frac_nxt  = frac_wrap ? 10'(frac_sum - {1'b0, frac_lim})
                                      : frac_sum[9:0];

    // Parabolic half-wave, peak just below positive full scale
    // The top phase bit flips the half-wave for the negative half-period
    wire [9:0]  half_cmp  = 10'h200 - {1'b0, phase_r[8:0]};
    wire [16:0] half_y    = 17'({8'h00, phase_r[8:0]} * {7'h00, half_cmp});
    wire [23:0] half_mag  = {half_y, 7'h00} - {16'h0000, half_y[16:9]};
    wire [23:0] sine_nxt  = phase_r[9] ? 24'(-half_mag) : half_mag;

    // Digital attenuation: whole 6 dB steps by shift, the rest by table
    // Every 12 counts is taken as one halving; the arithmetic shift truncates the low bits
    wire [4:0]  att_q     = 5'(atten_r / 8'h0c);                // RULE5
    wire [3:0]  att_rem   = 4'(atten_r - 8'(att_q * 5'h0c));    // RULE5
    wire [16:0] att_gain  = tsg_step_gain(att_rem);
    wire signed [41:0] att_prod = $signed(sine_r) * $signed({1'b0, att_gain});
    wire signed [23:0] att_frac = att_prod[39:16];
    wire        att_mute  = atten_r[7:4] == 4'hf;               // RULE5
    wire [23:0] att_nxt   = att_mute ? 24'h000000 : 24'(att_frac >>> att_q); // RULE5 RULE6

    // First-order ones-density modulator; 50 % density is code zero.
    // Codes are halved first so full scale lands on 25 % and 75 % density,
    // the same transfer that an external bitstream has.
    wire [23:0] mod_src   = (mode_r == tsg_pkg::TSG_MODE_LEVEL) ? level_r : att_r; // RULE8
    wire [23:0] mod_half  = 24'($signed(mod_src) >>> 1);        // RULE8 RULE13
    wire [23:0] mod_u     = mod_half ^ 24'h800000;              // RULE8 RULE13
    wire [24:0] mod_sum   = {1'b0, acc_r} + {1'b0, mod_u};

    // Output selection
    // The reserved gain code is clamped so the range stage never sees it
    wire        bit_nxt   = is_data ? bits_sync_r[1] : mod_sum[24]; // RULE12
    wire [2:0]  range_nxt = (gain_r > `TSG_GAIN_MAX) ? `TSG_GAIN_MAX : gain_r; // RULE4 RULE17
    wire [4:0]  pcode_nxt = align_s ? pb_r : pa_r;              // RULE9 RULE11

    // Read mux
    wire [31:0] st_word   = {19'h00000, align_s, mode_r, phase_r};
    wire [31:0] rd_nxt    =
        addr_hit_gm   ? {27'h0, mode_r, gain_r} :
        addr_hit_rate ? {19'h0, halve_r, mul_r, div_r} :
        addr_hit_att  ? {24'h0, atten_r} :
        addr_hit_lvl  ? {8'h00, level_r} :
        addr_hit_pul  ? {22'h0, pb_r, pa_r} :
        addr_hit_st   ? st_word : 32'h00000000;

    // Register file
    // Writes land at the strobe edge; the drive follows one cycle later
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gain_r  <= `TSG_RST_GAIN;
            mode_r  <= tsg_pkg::TSG_MODE_SINE;
            mul_r   <= `TSG_RST_MUL;
            div_r   <= `TSG_RST_DIV;
            halve_r <= 1'b0;
            atten_r <= `TSG_RST_ATTEN;
            level_r <= `TSG_RST_LEVEL;
            pa_r    <= `TSG_RST_PULSE;
            pb_r    <= `TSG_RST_PULSE;
        end
        else if (reg_wr)
        begin
            if (addr_hit_gm)
            begin
                gain_r <= reg_wdata[`TSG_GAIN_LSB +: 3];
                mode_r <= tsg_pkg::tsg_mode_t'(reg_wdata[`TSG_MODE_LSB +: 2]); // RULE15
            end
            if (addr_hit_rate)
            begin
                div_r   <= reg_wdata[`TSG_DIV_LSB +: 8];
                mul_r   <= reg_wdata[`TSG_MUL_LSB +: 4];
                halve_r <= reg_wdata[`TSG_HALVE_BIT];
            end
            if (addr_hit_att)
                atten_r <= reg_wdata[7:0];
            if (addr_hit_lvl)
                level_r <= reg_wdata[23:0];
            if (addr_hit_pul)
            begin
                pa_r <= reg_wdata[`TSG_PA_LSB +: 5];
                pb_r <= reg_wdata[`TSG_PB_LSB +: 5];
            end
        end
    end

    // Read data, valid the cycle after the strobe only
    // Zero outside that cycle keeps stale contents off the port
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= 32'h00000000;
        else
            rdata_r <= reg_rd ? rd_nxt : 32'h00000000;
    end

    // Pin synchronisers and align edge history
    // Only the second stage is read, so no logic sees a metastable value
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            align_sync_r <= 2'b00;
            bits_sync_r  <= 2'b00;
            align_d_r    <= 1'b0;
        end
        else
        begin
            align_sync_r <= {align_sync_r[0], align_pin};
            bits_sync_r  <= {bits_sync_r[0], switch_or_bitstream_pin};
            align_d_r    <= align_s;
        end
    end

    // Bit-rate divider; a data-mode align edge re-phases it
    // It runs in every mode so phase and modulator share one cadence
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt_r <= 4'(`TSG_BIT_PERIOD - 1);
        else if (is_data && align_up)
            tick_cnt_r <= 4'(`TSG_ALIGN_DELAY - 1);              // RULE16
        else if (tick)
            tick_cnt_r <= 4'(`TSG_BIT_PERIOD - 1);               // RULE12 RULE16
        else
            tick_cnt_r <= tick_cnt_r - 4'h1;
    end

    // Sine phase
    // A restart wins over a tick in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frac_r  <= 10'h000;
            phase_r <= 10'h000;
        end
        else if (restart)
        begin
            frac_r  <= 10'h000;                                 // RULE2 RULE3
            phase_r <= 10'h000;
        end
        else if (tick)
        begin
            frac_r  <= frac_nxt;                                // RULE1
            phase_r <= phase_r + {9'h000, frac_wrap};
        end
    end

    // Sample pipeline and modulator
    // Samples move every cycle; the modulator and output bit move on a tick
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sine_r <= 24'h000000;
            att_r  <= 24'h000000;
            acc_r  <= 24'h000000;
            bit_r  <= 1'b0;
        end
        else
        begin
            sine_r <= sine_nxt;
            att_r  <= att_nxt;
            if (is_data && align_up)
                acc_r <= 24'h000000;
            else if (tick)
            begin
                acc_r <= mod_sum[23:0];                         // RULE13
                bit_r <= bit_nxt;                               // RULE12 RULE13
            end
        end
    end

    // Converter drive
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_r <= 1'b0;
            zero_r   <= 1'b0;
            psel_r   <= 1'b0;
            pcode_r  <= 5'h00;
            range_r  <= 3'h0;
        end
        else
        begin
            strobe_r <= tick && !(is_data && align_up);
            zero_r   <= is_data && align_up;                    // RULE16
            psel_r   <= is_pulse;                               // RULE10
            pcode_r  <= is_pulse ? pcode_nxt : 5'h00;           // RULE9
            range_r  <= range_nxt;                              // RULE6 RULE14
        end
    end

    assign reg_rdata        = rdata_r;
    assign drive.pulse_sel  = psel_r;
    assign drive.pulse_code = pcode_r;
    assign drive.range_code = range_r;
    assign drive.main_bit   = bit_r;
    assign drive.bit_strobe = strobe_r;
    assign drive.out_zero   = zero_r;

endmodule

/* File: tsg_core_properties.sv */
// Port checker of tsg_core: register port, gain, mode and bit timing.
// Bound into every tsg_core; one clock, active-low reset.
`timescale 1ns/10ps
module tsg_core_properties #(
    parameter int ADDR_W = 3
) (
    // Clock and reset
    input wire logic                clk_sys,
    input wire logic                rst_n,
    // Register port
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic [31:0]         reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [31:0]         reg_rdata,
    // Converter drive
    input wire tsg_pkg::tsg_drive_t drive
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    wire w_gm = reg_wr && reg_addr == ADDR_W'(0);
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    AST_GAIN_MAP: assert property (w_gm && reg_wdata[2:0] != 3'h7
        |-> ##2 drive.range_code == $past(reg_wdata[2:0], 2))
        else $error("gain code not applied");
    AST_GAIN_RSV: assert property (w_gm && reg_wdata[2:0] == 3'h7
        |-> ##2 drive.range_code == 3'h6) else $error("reserved gain not held");
    AST_MODE_SEL: assert property (w_gm
        |-> ##2 drive.pulse_sel == ($past(reg_wdata[4:3], 2) == 2'b11))
        else $error("mode not applied");
    AST_STAT_MODE: assert property (reg_rd && reg_addr == ADDR_W'(5)
        |=> (reg_rdata[11:10] == 2'b11) == drive.pulse_sel) else $error("status mode");
    AST_PULSE_IDLE: assert property (!drive.pulse_sel |-> drive.pulse_code == 5'h0)
        else $error("pulse code outside pulse mode");
    AST_BIT_HOLD: assert property ($changed(drive.main_bit) |-> drive.bit_strobe)
        else $error("main bit changed without strobe");
    AST_BIT_GAP: assert property (drive.bit_strobe |=> !drive.bit_strobe [*8])
        else $error("bit strobes too close");
    AST_ZERO_ONE: assert property (drive.out_zero |=> !drive.out_zero)
        else $error("zero pulse longer than one cycle");
    AST_ZERO_BIT: assert property (drive.out_zero |-> ##8 drive.bit_strobe)
        else $error("sample not eight cycles after align");
    COV_ZERO: cover property (drive.out_zero);
    COV_PULSE: cover property (drive.pulse_sel && drive.pulse_code != 5'h0);
    COV_RSV: cover property (w_gm && reg_wdata[2:0] == 3'h7);
endmodule

bind tsg_core tsg_core_properties #(.ADDR_W(ADDR_W)) u_props (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive(drive));

/* File: tsg_core_tb.sv */
// Self-checking bench of tsg_core with the bitstream source model.
// Assumes the core, its checker and tsg_bit_src are compiled before.
`timescale 1ns/10ps
module tsg_core_tb;
    logic                clk_sys = 1'b0;
    logic                rst_n = 1'b0;
    logic [2:0]          reg_addr = 3'h0;
    logic [31:0]         reg_wdata = 32'h0;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [31:0]         reg_rdata;
    logic                align_pin = 1'b0;
    logic [3:0]          pattern = 4'h6;
    logic                sw_pin;
    tsg_pkg::tsg_drive_t drive;
    int                  n_errors = 0;
    int                  check_count = 0;

    always #2 clk_sys = ~clk_sys;

    tsg_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .align_pin(align_pin), .switch_or_bitstream_pin(sw_pin), .drive(drive));
    tsg_bit_src u_src (.clk_sys(clk_sys), .rst_n(rst_n), .align_pin(align_pin),
        .pattern(pattern), .bit_out(sw_pin));

    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_strobe(output int c);
        c = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            c++;
        end
        while (drive.bit_strobe !== 1'b1 && c < 40);
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [31:0] mask [5] = '{32'h1f, 32'h1fff, 32'hff, 32'hffffff, 32'h3ff};
        for (int i = 0; i < 8; i++)
        begin
            if (i != 5)
            begin
                rd(i[2:0], d);
                chk(d, 32'h0);
            end
        end
        wr(3'h6, 32'hffffffff);
        rd(3'h6, d);
        chk(d, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            wr(i[2:0], 32'hffffffff);
            rd(i[2:0], d);
            chk(d, mask[i]);
        end
    endtask

    task automatic t_modes;
        logic [31:0] d;
        for (int m = 0; m < 4; m++)
        begin
            for (int g = 0; g < 8; g++)
            begin
                wr(3'h0, 32'(m * 8 + g));
                @(posedge clk_sys);
                #1;
                chk(32'(drive.range_code), (g == 7) ? 32'h6 : 32'(g));
                chk(32'(drive.pulse_sel), 32'(m == 3));
                rd(3'h5, d);
                chk(32'(d[11:10]), 32'(m));
            end
        end
    endtask

    task automatic t_pulse;
        logic [4:0] pa [2] = '{5'h0f, 5'h00};
        logic [4:0] pb [2] = '{5'h11, 5'h1f};
        wr(3'h0, 32'h18);
        for (int i = 0; i < 2; i++)
        begin
            wr(3'h4, {22'h0, pb[i], pa[i]});
            repeat (4) @(posedge clk_sys);
            chk(32'(drive.pulse_code), 32'(pa[i]));
            align_pin <= 1'b1;
            repeat (5) @(posedge clk_sys);
            chk(32'(drive.pulse_code), 32'(pb[i]));
            wr(3'h0, 32'h1e);
            chk(32'(drive.pulse_code), 32'(pb[i]));
            @(posedge clk_sys);
            align_pin <= 1'b0;
            repeat (5) @(posedge clk_sys);
            chk(32'(drive.pulse_code), 32'(pa[i]));
            wr(3'h0, 32'h18);
        end
    endtask

    task automatic t_rate;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] rate [3] = '{32'h003, 32'h1101, 32'ha31};
        int          span [3] = '{640, 640, 800};
        int          step [3] = '{10, 20, 11};
        wr(3'h2, 32'h0);
        wr(3'h0, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(3'h1, rate[i]);
            rd(3'h5, a);
            repeat (span[i] - 2) @(posedge clk_sys);
            rd(3'h5, b);
            chk(32'((b[9:0] - a[9:0]) & 10'h3ff), 32'(step[i]));
        end
        chk(32'(b[9:0] != 10'h0), 32'h1);
        wr(3'h1, 32'h10ff);
        rd(3'h5, a);
        chk(32'(a[9:0]), 32'h0);
        wr(3'h1, 32'h0);
        repeat (300) @(posedge clk_sys);
        align_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(3'h5, a);
        chk(32'(a[9:0] < 10'h2), 32'h1);
        @(posedge clk_sys);
        align_pin <= 1'b0;
    endtask

    task automatic t_data;
        int c;
        int ones;
        ones = 0;
        wr(3'h0, 32'h10);
        repeat (4) @(posedge clk_sys);
        align_pin <= 1'b1;
        for (int i = 0; i < 20 && drive.out_zero !== 1'b1; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        chk(32'(drive.out_zero), 32'h1);
        wait_strobe(c);
        chk(32'(c), 32'h8);
        for (int j = 0; j < 8; j++)
        begin
            chk(32'(drive.main_bit), 32'(sw_pin));
            ones += (drive.main_bit === 1'b1) ? 1 : 0;
            wait_strobe(c);
            chk(32'(c), 32'h10);
        end
        chk(32'(ones), 32'h4);
        @(posedge clk_sys);
        align_pin <= 1'b0;
    endtask

    task automatic count_ones(output int ones);
        int c;
        ones = 0;
        wait_strobe(c);
        for (int k = 0; k < 16; k++)
        begin
            wait_strobe(c);
            ones += (drive.main_bit === 1'b1) ? 1 : 0;
        end
    endtask

    task automatic t_level;
        int ones;
        wr(3'h0, 32'h8);
        wr(3'h3, 32'hc00000);
        count_ones(ones);
        chk(32'(ones), 32'h6);
        wr(3'h3, 32'h0);
        count_ones(ones);
        chk(32'(ones), 32'h8);
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_modes();
        t_pulse();
        t_rate();
        t_level();
        t_data();
        end_of_test();
    end

    initial
    begin
        #80000;
        n_errors++;
        end_of_test();
    end
endmodule

/* File: tsg_pkg.sv */
// Types of the test signal generator.
// Used by tsg_core.sv; constants live in tsg_consts.svh.
package tsg_pkg;

    typedef enum logic [1:0] {
        TSG_MODE_SINE  = 2'b00,
        TSG_MODE_LEVEL = 2'b01,
        TSG_MODE_DATA  = 2'b10,
        TSG_MODE_PULSE = 2'b11
    } tsg_mode_t;

    // Drive of the analog converter stages
    typedef struct packed {
        logic       pulse_sel;
        logic [4:0] pulse_code;
        logic [2:0] range_code;
        logic       main_bit;
        logic       bit_strobe;
        logic       out_zero;
    } tsg_drive_t;

endpackage
